// file: design/bcd_calendar_alarm_timer.sv
// BCD calendar with alarm, update events and periodic timer on Wishbone
// ----------------------------------------------------------------------
// Operation
// R1 - Halt freezes every calendar counter from seconds to year.
// R2 - Halt suppresses update events and alarm events.
// R3 - Halt holds the whole prescaler chain, 4096Hz down to 1Hz, in reset.
// R4 - Count lock value 10101010 stops count-up; other values let it resume.
// R5 - All time and date counters are packed BCD.
// R6 - Date wraps to 01 after 31, 30 or 28 according to month.
// R7 - Year multiple of four is leap; February then reaches 29.
// R8 - Year counts 00 through 99 then wraps to 00.
// R9 - Date, month, year updating correct from 2001 to 2099.
// R10 - Update event on each second or each minute update, per select.
// R11 - Update select 0 means seconds, 1 means minutes.
// R12 - Update event sets update flag, held until software clears it.
// R13 - Event flags clear on written zero; written one has no effect.
// R14 - Alarm fires 8 slow crystal periods after enabled fields match.
// R15 - Alarm is edge based; fires only when counters advance into match.
// R16 - Alarm event sets alarm flag, held until software clears it.
// R17 - Software clears alarm enable before changing alarm settings.
// R18 - Weekday mode uses field as day bitmask; date mode compares BCD.
// R19 - Each wildcard drops its field from the alarm comparison.
// R20 - All three wildcards set gives one alarm every minute.
// R21 - Source select 00 4096Hz, 01 64Hz, 10 1Hz, 11 per minute.
// R22 - Setting run starts countdown from preset; clearing it stops.
// R23 - Periodic interval is source period times preset, 1 to 4095.
// R24 - First interval may be short by one source period, never longer.
// R25 - Periodic flag sets on expiry only while its enable is high.
// R26 - A preset of zero never produces a periodic event.
// ----------------------------------------------------------------------
`timescale 1ns/1ps

module bcd_calendar_alarm_timer (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		logic [7:0] r;
		if (v[3:0] == 4'h9) begin
			r = {4'(v[7:4] + 4'h1), 4'h0};
		end else begin
			r = {v[7:4], 4'(v[3:0] + 4'h1)};
		end
		return r;
	endfunction

	// Tens parity and the low two units bits decide the year modulo four in BCD
	function automatic logic [7:0] month_length(input logic [7:0] mon,
		input logic [7:0] yr);
		logic leap;
		logic [7:0] len;
		leap = 2'(yr[1:0] + {yr[4], 1'b0}) == 2'h0; // R7 R9
		len = calendar_pkg::DAYS_31;
		if (mon == calendar_pkg::FEBRUARY) begin
			len = leap ? calendar_pkg::DAYS_29 : calendar_pkg::DAYS_28;
		end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 ||
			mon == 8'h11) begin
			len = calendar_pkg::DAYS_30; // R6
		end
		return len;
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	logic [24:0] acc_reg, acc_next;
	logic [25:0] acc_sum;
	logic xtal_tick;
	logic [14:0] pre_reg, pre_next;
	logic tick_4096, tick_64, tick_1hz;
	calendar_pkg::time_s cal_reg, cal_next, cal_adv;
	calendar_pkg::cfg_s cfg_reg, cfg_next;
	logic halt, locked;
	logic sec_step, min_step, hour_step, day_step, mon_step, yr_step;
	logic [7:0] mlen;
	logic day_ok, hour_ok, min_ok, alarm_match;
	logic al_pend_reg, al_pend_next;
	logic [3:0] al_cnt_reg, al_cnt_next;
	logic alarm_fire;
	logic [11:0] per_cnt_reg, per_cnt_next;
	logic src_tick, periodic_fire, update_fire;
	logic upd_flag_reg, upd_flag_next;
	logic per_flag_reg, per_flag_next;
	logic al_flag_reg, al_flag_next;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic [7:0] rd_byte;
	logic bus_hit, wr_fire;
	logic [7:0] wb;

	assign halt = cfg_reg.calendar_halt;
	assign locked = cfg_reg.calendar_count_lock == calendar_pkg::COUNT_LOCK_KEY;
	assign bus_hit = cyc_i & stb_i;
	// Write lands at the edge where the master sees ack
	assign wr_fire = bus_hit & ack_reg & we_i & sel_i[0];
	assign wb = dat_i[7:0];
	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	// ------------------------------------------------------------------
	// Slow crystal divider and prescaler
	// ------------------------------------------------------------------
	// Phase accumulator: 25 MHz is no integer multiple of the crystal rate
	always_comb begin
		acc_sum = {1'b0, acc_reg} + calendar_pkg::SLOW_CRYSTAL_RATE;
		xtal_tick = acc_sum >= calendar_pkg::CLK_RATE_HZ;
		acc_next = xtal_tick ? 25'(acc_sum - calendar_pkg::CLK_RATE_HZ)
			: acc_sum[24:0];
		pre_next = pre_reg;
		if (halt) begin
			pre_next = '0; // R3
		end else if (xtal_tick) begin
			pre_next = 15'(pre_reg + 15'h0001);
		end
		tick_4096 = xtal_tick & ~halt &
			((pre_reg & calendar_pkg::TAP_4096_MASK) ==
			calendar_pkg::TAP_4096_MASK);
		tick_64 = xtal_tick & ~halt &
			((pre_reg & calendar_pkg::TAP_64_MASK) ==
			calendar_pkg::TAP_64_MASK);
		tick_1hz = xtal_tick & ~halt & (pre_reg == calendar_pkg::TAP_1HZ_MASK);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_reg <= '0;
			pre_reg <= '0;
		end else begin
			acc_reg <= acc_next;
			pre_reg <= pre_next;
		end
	end

	// ------------------------------------------------------------------
	// Calendar counters
	// ------------------------------------------------------------------
	always_comb begin
		mlen = month_length(cal_reg.month, cal_reg.year);
		sec_step = tick_1hz & ~locked; // R1 R4
		min_step = sec_step & (cal_reg.seconds == calendar_pkg::SEC_MAX);
		hour_step = min_step & (cal_reg.minutes == calendar_pkg::SEC_MAX);
		day_step = hour_step & (cal_reg.hours == calendar_pkg::HOUR_MAX);
		mon_step = day_step & (cal_reg.date == mlen);
		yr_step = mon_step & (cal_reg.month == calendar_pkg::MONTH_MAX);
		cal_adv = cal_reg;
		if (sec_step) begin
			cal_adv.seconds = min_step ? calendar_pkg::BCD_ZERO
				: bcd_inc(cal_reg.seconds); // R5
		end
		if (min_step) begin
			cal_adv.minutes = hour_step ? calendar_pkg::BCD_ZERO
				: bcd_inc(cal_reg.minutes);
		end
		if (hour_step) begin
			cal_adv.hours = day_step ? calendar_pkg::BCD_ZERO
				: bcd_inc(cal_reg.hours);
		end
		if (day_step) begin
			cal_adv.weekday = (cal_reg.weekday == calendar_pkg::WEEK_MAX)
				? calendar_pkg::BCD_ZERO : bcd_inc(cal_reg.weekday);
			cal_adv.date = mon_step ? calendar_pkg::BCD_ONE
				: bcd_inc(cal_reg.date); // R6 R7
		end
		if (mon_step) begin
			cal_adv.month = yr_step ? calendar_pkg::BCD_ONE
				: bcd_inc(cal_reg.month);
		end
		if (yr_step) begin
			cal_adv.year = (cal_reg.year == calendar_pkg::YEAR_MAX)
				? calendar_pkg::BCD_ZERO : bcd_inc(cal_reg.year); // R8 R9
		end
		cal_next = cal_adv;
		// Software write wins over a tick in the same cycle
		if (wr_fire) begin
			unique case (adr_i)
				calendar_pkg::OFS_SECONDS: begin
					cal_next.seconds = wb & calendar_pkg::MASK_SECONDS;
				end
				calendar_pkg::OFS_MINUTES: begin
					cal_next.minutes = wb & calendar_pkg::MASK_SECONDS;
				end
				calendar_pkg::OFS_HOURS: begin
					cal_next.hours = wb & calendar_pkg::MASK_HOURS;
				end
				calendar_pkg::OFS_WEEKDAY: begin
					cal_next.weekday = wb & calendar_pkg::MASK_WEEKDAY;
				end
				calendar_pkg::OFS_DATE: begin
					cal_next.date = wb & calendar_pkg::MASK_HOURS;
				end
				calendar_pkg::OFS_MONTH: begin
					cal_next.month = wb & calendar_pkg::MASK_MONTH;
				end
				calendar_pkg::OFS_YEAR: begin
					cal_next.year = wb;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cal_reg <= calendar_pkg::TIME_RESET;
		end else begin
			cal_reg <= cal_next;
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------
	always_comb begin
		cfg_next = cfg_reg;
		if (wr_fire) begin
			unique case (adr_i)
				calendar_pkg::OFS_ALARM_MINUTE: begin
					cfg_next.alarm_minute = wb;
				end
				calendar_pkg::OFS_ALARM_HOUR: begin
					cfg_next.alarm_hour = wb & calendar_pkg::MASK_ALARM_HOUR;
				end
				calendar_pkg::OFS_ALARM_WEEKDAY: begin
					cfg_next.weekday_alarm_field = wb;
				end
				calendar_pkg::OFS_PRESET_LOW: begin
					cfg_next.preset[7:0] = wb;
				end
				calendar_pkg::OFS_PRESET_HIGH: begin
					cfg_next.preset[11:8] = wb[3:0];
				end
				calendar_pkg::OFS_TIMER_CTRL: begin
					cfg_next.week_or_date_select =
						wb[calendar_pkg::WEEK_OR_DATE_BIT];
					cfg_next.update_period_select =
						wb[calendar_pkg::UPDATE_SELECT_BIT];
					cfg_next.periodic_run = wb[calendar_pkg::PERIODIC_RUN_BIT];
					cfg_next.periodic_source_select = wb[1:0];
				end
				calendar_pkg::OFS_EVENT_CTRL: begin
					cfg_next.update_irq_enable = wb[calendar_pkg::UPDATE_BIT];
					cfg_next.periodic_irq_enable =
						wb[calendar_pkg::PERIODIC_BIT];
					cfg_next.alarm_irq_enable = wb[calendar_pkg::ALARM_BIT];
					cfg_next.calendar_halt = wb[calendar_pkg::HALT_BIT];
				end
				calendar_pkg::OFS_COUNT_LOCK: begin
					cfg_next.calendar_count_lock = wb; // R4
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg <= calendar_pkg::CFG_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// ------------------------------------------------------------------
	// Alarm
	// ------------------------------------------------------------------
	// Checked only on a minute advance, so equal-to-now never fires at once
	always_comb begin
		day_ok = cfg_reg.weekday_alarm_field[calendar_pkg::WILDCARD_BIT]; // R19
		if (!day_ok) begin
			if (cfg_reg.week_or_date_select) begin
				day_ok = cfg_reg.weekday_alarm_field[5:0] ==
					cal_adv.date[5:0]; // R18
			end else begin
				day_ok = cfg_reg.weekday_alarm_field[cal_adv.weekday[2:0]]; // R18
			end
		end
		hour_ok = cfg_reg.alarm_hour[calendar_pkg::WILDCARD_BIT] |
			(cfg_reg.alarm_hour[5:0] == cal_adv.hours[5:0]); // R19
		min_ok = cfg_reg.alarm_minute[calendar_pkg::WILDCARD_BIT] |
			(cfg_reg.alarm_minute[6:0] == cal_adv.minutes[6:0]); // R19
		alarm_match = min_step & day_ok & hour_ok & min_ok; // R15 R20
		alarm_fire = al_pend_reg & xtal_tick & ~halt &
			(al_cnt_reg == 4'(calendar_pkg::ALARM_DELAY_PERIODS - 4'h1)); // R14
		al_pend_next = al_pend_reg;
		al_cnt_next = al_cnt_reg;
		if (halt) begin
			al_pend_next = 1'b0; // R2
			al_cnt_next = '0;
		end else if (alarm_match) begin
			al_pend_next = 1'b1;
			al_cnt_next = '0;
		end else if (alarm_fire) begin
			al_pend_next = 1'b0;
			al_cnt_next = '0;
		end else if (al_pend_reg & xtal_tick) begin
			al_cnt_next = 4'(al_cnt_reg + 4'h1); // R14
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			al_pend_reg <= 1'b0;
			al_cnt_reg <= '0;
		end else begin
			al_pend_reg <= al_pend_next;
			al_cnt_reg <= al_cnt_next;
		end
	end

	// ------------------------------------------------------------------
	// Periodic timer
	// ------------------------------------------------------------------
	// First tick comes within one source period, so interval only shortens
	always_comb begin
		unique case (cfg_reg.periodic_source_select)
			calendar_pkg::SRC_4096HZ: src_tick = tick_4096; // R21
			calendar_pkg::SRC_64HZ: src_tick = tick_64;
			calendar_pkg::SRC_1HZ: src_tick = tick_1hz;
			calendar_pkg::SRC_MINUTE: src_tick = min_step;
		endcase
		periodic_fire = cfg_reg.periodic_run & src_tick &
			(per_cnt_reg == 12'h001); // R23 R26
		per_cnt_next = per_cnt_reg;
		if (!cfg_reg.periodic_run || halt) begin
			per_cnt_next = cfg_reg.preset; // R22 R24
		end else if (periodic_fire) begin
			per_cnt_next = cfg_reg.preset; // R23
		end else if (src_tick && per_cnt_reg != 12'h000) begin
			per_cnt_next = 12'(per_cnt_reg - 12'h001); // R22
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			per_cnt_reg <= '0;
		end else begin
			per_cnt_reg <= per_cnt_next;
		end
	end

	// ------------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------------
	always_comb begin
		update_fire = cfg_reg.update_period_select ? min_step : sec_step; // R10 R11 R2
		upd_flag_next = upd_flag_reg;
		per_flag_next = per_flag_reg;
		al_flag_next = al_flag_reg;
		if (wr_fire && adr_i == calendar_pkg::OFS_EVENT_FLAGS) begin
			upd_flag_next = upd_flag_reg & wb[calendar_pkg::UPDATE_BIT]; // R13
			per_flag_next = per_flag_reg & wb[calendar_pkg::PERIODIC_BIT];
			al_flag_next = al_flag_reg & wb[calendar_pkg::ALARM_BIT];
		end
		// Set beats a clear landing in the same cycle
		if (update_fire) begin
			upd_flag_next = 1'b1; // R12
		end
		if (periodic_fire && cfg_reg.periodic_irq_enable) begin
			per_flag_next = 1'b1; // R25
		end
		if (alarm_fire) begin
			al_flag_next = 1'b1; // R16
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			upd_flag_reg <= 1'b0;
			per_flag_reg <= 1'b0;
			al_flag_reg <= 1'b0;
		end else begin
			upd_flag_reg <= upd_flag_next;
			per_flag_reg <= per_flag_next;
			al_flag_reg <= al_flag_next;
		end
	end

	// ------------------------------------------------------------------
	// Wishbone read path and acknowledge
	// ------------------------------------------------------------------
	always_comb begin
		unique case (adr_i)
			calendar_pkg::OFS_SECONDS: rd_byte = cal_reg.seconds;
			calendar_pkg::OFS_MINUTES: rd_byte = cal_reg.minutes;
			calendar_pkg::OFS_HOURS: rd_byte = cal_reg.hours;
			calendar_pkg::OFS_WEEKDAY: rd_byte = cal_reg.weekday;
			calendar_pkg::OFS_DATE: rd_byte = cal_reg.date;
			calendar_pkg::OFS_MONTH: rd_byte = cal_reg.month;
			calendar_pkg::OFS_YEAR: rd_byte = cal_reg.year;
			calendar_pkg::OFS_ALARM_MINUTE: rd_byte = cfg_reg.alarm_minute;
			calendar_pkg::OFS_ALARM_HOUR: rd_byte = cfg_reg.alarm_hour;
			calendar_pkg::OFS_ALARM_WEEKDAY: begin
				rd_byte = cfg_reg.weekday_alarm_field;
			end
			calendar_pkg::OFS_PRESET_LOW: rd_byte = cfg_reg.preset[7:0];
			calendar_pkg::OFS_PRESET_HIGH: begin
				rd_byte = {4'h0, cfg_reg.preset[11:8]};
			end
			calendar_pkg::OFS_TIMER_CTRL: begin
				rd_byte = {1'b0, cfg_reg.week_or_date_select,
					cfg_reg.update_period_select, cfg_reg.periodic_run,
					2'h0, cfg_reg.periodic_source_select};
			end
			calendar_pkg::OFS_EVENT_FLAGS: begin
				rd_byte = {2'h0, upd_flag_reg, per_flag_reg, al_flag_reg, 3'h0};
			end
			calendar_pkg::OFS_EVENT_CTRL: begin
				rd_byte = {2'h0, cfg_reg.update_irq_enable,
					cfg_reg.periodic_irq_enable, cfg_reg.alarm_irq_enable,
					2'h0, cfg_reg.calendar_halt};
			end
			calendar_pkg::OFS_COUNT_LOCK: rd_byte = cfg_reg.calendar_count_lock;
			default: rd_byte = 8'h00;
		endcase
		ack_next = bus_hit & ~ack_reg;
		dat_next = dat_reg;
		if (bus_hit && !ack_reg) begin
			dat_next = {24'h000000, rd_byte};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= '0;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

endmodule

// file: design/calendar_pkg.sv
// Constants, register map and carrier types of the BCD calendar block
package calendar_pkg;

	// ------------------------------------------------------------------
	// Rates and divider taps
	// ------------------------------------------------------------------
	localparam logic [25:0] CLK_RATE_HZ = 26'h17D7840;
	localparam logic [25:0] SLOW_CRYSTAL_RATE = 26'h0008000;
	localparam logic [14:0] TAP_4096_MASK = 15'h0007;
	localparam logic [14:0] TAP_64_MASK = 15'h01FF;
	localparam logic [14:0] TAP_1HZ_MASK = 15'h7FFF;
	localparam logic [3:0] ALARM_DELAY_PERIODS = 4'h8;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_SECONDS = 8'h00;
	localparam logic [7:0] OFS_MINUTES = 8'h04;
	localparam logic [7:0] OFS_HOURS = 8'h08;
	localparam logic [7:0] OFS_WEEKDAY = 8'h0C;
	localparam logic [7:0] OFS_DATE = 8'h10;
	localparam logic [7:0] OFS_MONTH = 8'h14;
	localparam logic [7:0] OFS_YEAR = 8'h18;
	localparam logic [7:0] OFS_ALARM_MINUTE = 8'h1C;
	localparam logic [7:0] OFS_ALARM_HOUR = 8'h20;
	localparam logic [7:0] OFS_ALARM_WEEKDAY = 8'h24;
	localparam logic [7:0] OFS_PRESET_LOW = 8'h28;
	localparam logic [7:0] OFS_PRESET_HIGH = 8'h2C;
	localparam logic [7:0] OFS_TIMER_CTRL = 8'h30;
	localparam logic [7:0] OFS_EVENT_FLAGS = 8'h34;
	localparam logic [7:0] OFS_EVENT_CTRL = 8'h38;
	localparam logic [7:0] OFS_COUNT_LOCK = 8'h3C;

	// ------------------------------------------------------------------
	// Field positions, masks and keys
	// ------------------------------------------------------------------
	localparam int WILDCARD_BIT = 7;
	localparam int WEEK_OR_DATE_BIT = 6;
	localparam int UPDATE_SELECT_BIT = 5;
	localparam int PERIODIC_RUN_BIT = 4;
	localparam int UPDATE_BIT = 5;
	localparam int PERIODIC_BIT = 4;
	localparam int ALARM_BIT = 3;
	localparam int HALT_BIT = 0;
	localparam logic [7:0] COUNT_LOCK_KEY = 8'hAA;
	localparam logic [1:0] SRC_4096HZ = 2'h0;
	localparam logic [1:0] SRC_64HZ = 2'h1;
	localparam logic [1:0] SRC_1HZ = 2'h2;
	localparam logic [1:0] SRC_MINUTE = 2'h3;
	localparam logic [7:0] MASK_SECONDS = 8'h7F;
	localparam logic [7:0] MASK_HOURS = 8'h3F;
	localparam logic [7:0] MASK_WEEKDAY = 8'h07;
	localparam logic [7:0] MASK_MONTH = 8'h1F;
	localparam logic [7:0] MASK_ALARM_HOUR = 8'hBF;

	// ------------------------------------------------------------------
	// BCD limits
	// ------------------------------------------------------------------
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	localparam logic [7:0] SEC_MAX = 8'h59;
	localparam logic [7:0] HOUR_MAX = 8'h23;
	localparam logic [7:0] WEEK_MAX = 8'h06;
	localparam logic [7:0] MONTH_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [7:0] FEBRUARY = 8'h02;
	localparam logic [7:0] DAYS_31 = 8'h31;
	localparam logic [7:0] DAYS_30 = 8'h30;
	localparam logic [7:0] DAYS_29 = 8'h29;
	localparam logic [7:0] DAYS_28 = 8'h28;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] weekday;
		logic [7:0] hours;
		logic [7:0] minutes;
		logic [7:0] seconds;
	} time_s;

	typedef struct packed {
		logic [7:0] alarm_minute;
		logic [7:0] alarm_hour;
		logic [7:0] weekday_alarm_field;
		logic [11:0] preset;
		logic week_or_date_select;
		logic update_period_select;
		logic periodic_run;
		logic [1:0] periodic_source_select;
		logic update_irq_enable;
		logic periodic_irq_enable;
		logic alarm_irq_enable;
		logic calendar_halt;
		logic [7:0] calendar_count_lock;
	} cfg_s;

	localparam time_s TIME_RESET = '{year: 8'h01, month: 8'h01,
		date: 8'h01, weekday: 8'h00, hours: 8'h00, minutes: 8'h00,
		seconds: 8'h00};
	localparam cfg_s CFG_RESET = '0;

endpackage

// file: verif/bcd_calendar_alarm_timer_props.sv
// Port checker for the BCD calendar block
`timescale 1ns/1ps

module calendar_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o
);
	logic [7:0] lock_reg;
	logic [7:0] lock_next;
	logic rd;
	logic wr;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	assign rd = ack_o && !we_i;
	assign wr = ack_o && we_i && sel_i[0];
	// -----------------------------------------------------------------
	// Shadow of the lock key, updated on the acknowledged write
	// -----------------------------------------------------------------
	always_comb begin
		lock_next = lock_reg;
		if (wr && adr_i == calendar_pkg::OFS_COUNT_LOCK) begin
			lock_next = dat_i[7:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_reg <= 8'h00;
		end else begin
			lock_reg <= lock_next;
		end
	end
	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	a_seconds_bcd: assert property (
		rd && adr_i == calendar_pkg::OFS_SECONDS |->
		dat_o[7:4] <= 4'h5 && dat_o[3:0] <= 4'h9)
		else $error("seconds not BCD");
	a_hours_bcd: assert property (
		rd && adr_i == calendar_pkg::OFS_HOURS |->
		dat_o[7:0] <= 8'h23 && dat_o[3:0] <= 4'h9)
		else $error("hours not BCD");
	a_date_range: assert property (
		rd && adr_i == calendar_pkg::OFS_DATE |->
		dat_o[7:0] inside {[8'h01:8'h31]})
		else $error("date out of range");
	a_month_range: assert property (
		rd && adr_i == calendar_pkg::OFS_MONTH |->
		dat_o[7:0] inside {[8'h01:8'h12]})
		else $error("month out of range");
	a_lock_readback: assert property (
		rd && adr_i == calendar_pkg::OFS_COUNT_LOCK |->
		dat_o[7:0] == lock_reg)
		else $error("lock key lost");
	a_preset_high: assert property (
		rd && adr_i == calendar_pkg::OFS_PRESET_HIGH |-> dat_o[31:4] == '0)
		else $error("preset wider than 12 bits");
	a_flags_unused: assert property (
		rd && adr_i == calendar_pkg::OFS_EVENT_FLAGS |->
		dat_o[31:6] == '0 && dat_o[2:0] == 3'h0)
		else $error("flag byte has stray bits");
	a_ctrl_unused: assert property (
		rd && adr_i == calendar_pkg::OFS_TIMER_CTRL |->
		dat_o[7] == 1'b0 && dat_o[3:2] == 2'h0)
		else $error("timer control has stray bits");
	a_ack_pulse: assert property (
		cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack not a one cycle answer");
	// Main scenarios
	c_lock: cover property (wr && adr_i == calendar_pkg::OFS_COUNT_LOCK);
	c_run: cover property (wr && adr_i == calendar_pkg::OFS_TIMER_CTRL);
	c_flag: cover property (rd && adr_i == calendar_pkg::OFS_EVENT_FLAGS
		&& dat_o[4]);
endmodule

// file: verif/tb_bcd_calendar_alarm_timer.sv
// Self-checking bench for the BCD calendar block
`timescale 1ns/1ps

module tb_bcd_calendar_alarm_timer;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic [31:0] rd_val;
	int failures = 0;
	int checked = 0;

	always #20 clk_i = ~clk_i;

	bcd_calendar_alarm_timer dut (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	task automatic close_out();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Master waits for ack, never a fixed count
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		sel_i <= 4'h1;
		dat_i <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rd_val = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		if (n >= 20) begin
			failures++;
			close_out();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e,
		input string name);
		bus(1'b0, a, 8'h00);
		checked++;
		if (rd_val !== {24'h000000, e}) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, e, rd_val);
		end
	endtask

	// Bounded poll of the periodic flag
	task automatic wait_flag(input int limit);
		int k;
		k = 0;
		bus(1'b0, calendar_pkg::OFS_EVENT_FLAGS, 8'h00);
		while (rd_val[4] !== 1'b1 && k < limit) begin
			bus(1'b0, calendar_pkg::OFS_EVENT_FLAGS, 8'h00);
			k++;
		end
		rchk(calendar_pkg::OFS_EVENT_FLAGS, 8'h10, "periodic flag");
		if (k >= limit) begin
			close_out();
		end
	endtask

	task automatic run_idle(input logic [7:0] pre, input logic [7:0] ev,
		input string name);
		wr(calendar_pkg::OFS_TIMER_CTRL, 8'h00);
		wr(calendar_pkg::OFS_PRESET_LOW, pre);
		wr(calendar_pkg::OFS_EVENT_CTRL, ev);
		wr(calendar_pkg::OFS_TIMER_CTRL, 8'h10);
		repeat (7000) @(posedge clk_i);
		rchk(calendar_pkg::OFS_EVENT_FLAGS, 8'h00, name);
	endtask

	// -----------------------------------------------------------------
	// Sequence
	// -----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(calendar_pkg::OFS_SECONDS, 8'h00, "seconds");
		rchk(calendar_pkg::OFS_DATE, 8'h01, "date");
		rchk(calendar_pkg::OFS_MONTH, 8'h01, "month");
		rchk(calendar_pkg::OFS_YEAR, 8'h01, "year");
		rchk(calendar_pkg::OFS_COUNT_LOCK, 8'h00, "lock");
		rchk(8'hFC, 8'h00, "unmapped");
		$display("test reset_values done");
		wr(calendar_pkg::OFS_COUNT_LOCK, 8'hAA);
		rchk(calendar_pkg::OFS_COUNT_LOCK, 8'hAA, "lock");
		wr(calendar_pkg::OFS_SECONDS, 8'h59);
		rchk(calendar_pkg::OFS_SECONDS, 8'h59, "seconds");
		wr(calendar_pkg::OFS_COUNT_LOCK, 8'h55);
		rchk(calendar_pkg::OFS_COUNT_LOCK, 8'h55, "lock");
		for (int s = 0; s < 4; s++) begin
			wr(calendar_pkg::OFS_TIMER_CTRL, 8'(s));
			rchk(calendar_pkg::OFS_TIMER_CTRL, 8'(s), "source");
		end
		wr(calendar_pkg::OFS_EVENT_FLAGS, 8'hFF);
		rchk(calendar_pkg::OFS_EVENT_FLAGS, 8'h00, "flags");
		// Alarm enable off before touching alarm fields
		wr(calendar_pkg::OFS_EVENT_CTRL, 8'h00);
		wr(calendar_pkg::OFS_ALARM_HOUR, 8'hFF);
		rchk(calendar_pkg::OFS_ALARM_HOUR, 8'hBF, "alarm hour");
		wr(calendar_pkg::OFS_PRESET_HIGH, 8'hFF);
		rchk(calendar_pkg::OFS_PRESET_HIGH, 8'h0F, "preset high");
		$display("test registers done");
		// Preset 2 on the 4096Hz tap: not before one period
		wr(calendar_pkg::OFS_TIMER_CTRL, 8'h00);
		wr(calendar_pkg::OFS_PRESET_LOW, 8'h02);
		wr(calendar_pkg::OFS_PRESET_HIGH, 8'h00);
		wr(calendar_pkg::OFS_EVENT_CTRL, 8'h10);
		wr(calendar_pkg::OFS_TIMER_CTRL, 8'h10);
		repeat (5900) @(posedge clk_i);
		rchk(calendar_pkg::OFS_EVENT_FLAGS, 8'h00, "early");
		wait_flag(2200);
		wr(calendar_pkg::OFS_TIMER_CTRL, 8'h00);
		wr(calendar_pkg::OFS_EVENT_FLAGS, 8'hFF);
		rchk(calendar_pkg::OFS_EVENT_FLAGS, 8'h10, "kept");
		wr(calendar_pkg::OFS_EVENT_FLAGS, 8'h00);
		rchk(calendar_pkg::OFS_EVENT_FLAGS, 8'h00, "cleared");
		$display("test periodic done");
		run_idle(8'h01, 8'h00, "no enable");
		run_idle(8'h00, 8'h10, "preset zero");
		run_idle(8'h01, 8'h11, "halted");
		rchk(calendar_pkg::OFS_SECONDS, 8'h59, "frozen");
		// Halt released: divider restarts from reset
		wr(calendar_pkg::OFS_EVENT_CTRL, 8'h10);
		// Divider restarts at zero, so eight crystal ticks pass first
		repeat (5200) @(posedge clk_i);
		rchk(calendar_pkg::OFS_EVENT_FLAGS, 8'h00, "restart");
		wait_flag(2300);
		$display("test halt done");
		close_out();
	end
endmodule

bind bcd_calendar_alarm_timer calendar_props props (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
	.ack_o(ack_o));
